// ### sarr_readout.sv
// Serial result readout: select-framed SAR sequencer and bit shifter.
// Assumes select, serial clock and comparator are synchronous to i_clk.

// ==========================================================
// Bit FIFO between the decision logic and the shifter
// Decisions run three falls ahead of the shifter, so at most three bits wait;
// eight words leave slack, so the search never stalls in normal use.
module sarr_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_flush,
	// Fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	// Occupancy needs one bit more than the pointers
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] cnt_ff;
	logic push;
	logic pop;

	// Honest flags straight from the occupancy count
	assign o_in_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_ff != '0);
	assign o_out_data = mem[rd_ptr_ff];
	assign push = i_in_valid & o_in_ready;
	assign pop = i_out_ready & o_out_valid;

	// Pointers and count; flush drops a partial frame
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
		end else if (i_flush) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Storage needs no reset; reads are gated by the count
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_ff] <= i_in_data;
		end
	end
endmodule : sarr_fifo

// ==========================================================
// Top: sequencer and serial output
// The serial clock is only a level seen on i_clk; each level must last at
// least one core cycle, or a fall is missed and the frame slips.
module sarr_readout (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Host link
	input wire logic i_select_n,
	input wire logic i_sclk,
	output logic o_serial_result_out,
	output logic o_serial_result_oe,
	// Analog front end
	input wire logic i_cmp_above,
	output logic [11:0] o_dac_trial,
	output logic o_sample_hold,
	// Parallel result
	output logic [11:0] o_result,
	output logic o_result_valid
);
	// Sequencer state in one register, next value built beside it; the bit buffer keeps its own
	sarr_pkg::sarr_state_s s_ff;
	sarr_pkg::sarr_state_s nxt_s;
	logic fall;
	logic cs_fall;
	logic push;
	logic pop;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_data;
	logic [11:0] kept;

	// Edge detects on the synchronously sampled pins
	assign fall = s_ff.sclk_q & ~i_sclk;
	assign cs_fall = s_ff.cs_q_n & ~i_select_n;
	// Comparator keeps or drops the trial bit; codes rise with input
	assign kept = i_cmp_above ? s_ff.trial : (s_ff.trial & ~s_ff.mask);
	// Decide one bit on each of the first twelve serial clock falls
	assign push = (s_ff.mode == sarr_pkg::ST_CONV) & fall & ~i_select_n &
		(s_ff.cnt <= sarr_pkg::CNT_LAST_DECIDE) & (s_ff.mask != sarr_pkg::ZERO_CODE);
	// Result bits leave after the leading zeros
	assign pop = (s_ff.mode == sarr_pkg::ST_CONV) & fall & ~i_select_n &
		(s_ff.cnt >= sarr_pkg::CNT_FIRST_DATA) & (s_ff.cnt < sarr_pkg::CNT_RELEASE);

	// Bit buffer; a high select flushes whatever an aborted frame left
	sarr_fifo #(
		.WIDTH(1),
		.DEPTH(sarr_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_flush(i_select_n),
		.i_in_valid(push),
		.o_in_ready(fifo_in_ready),
		.i_in_data(i_cmp_above),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(pop),
		.o_out_data(fifo_out_data)
	);

	// Next-state logic
	always_comb begin
		nxt_s = s_ff;
		nxt_s.sclk_q = i_sclk;
		nxt_s.cs_q_n = i_select_n;
		nxt_s.sample = 1'b0;
		nxt_s.res_valid = 1'b0;
		// Deselect wins over every state, so an aborted frame leaves no result
		if (i_select_n) begin
			// No part in any transfer while deselected
			nxt_s.mode = sarr_pkg::ST_IDLE;
			nxt_s.oe = 1'b0;
			nxt_s.dout = 1'b0;
			nxt_s.cnt = '0;
		end else begin
			unique case (s_ff.mode)
				sarr_pkg::ST_IDLE: begin
					// Select fall samples and drives a zero next cycle
					if (cs_fall) begin
						nxt_s.mode = sarr_pkg::ST_CONV;
						nxt_s.cnt = '0;
						nxt_s.oe = 1'b1;
						nxt_s.dout = 1'b0;
						nxt_s.trial = sarr_pkg::TRIAL_START;
						nxt_s.mask = sarr_pkg::TRIAL_START;
						nxt_s.sample = 1'b1;
					end
				end
				sarr_pkg::ST_CONV: begin
					if (fall) begin
						nxt_s.cnt = s_ff.cnt + 5'h01;
						// A full buffer holds the search rather than lose a bit
						if (push && fifo_in_ready) begin
							nxt_s.trial = kept | (s_ff.mask >> 1);
							nxt_s.mask = s_ff.mask >> 1;
							if (s_ff.cnt == sarr_pkg::CNT_LAST_DECIDE) begin
								nxt_s.result = kept;
								nxt_s.res_valid = 1'b1;
							end
						end
						// Data moves only on falling edges
						if (pop) begin
							nxt_s.dout = fifo_out_valid ? fifo_out_data : 1'b0;
						end else begin
							nxt_s.dout = 1'b0;
						end
						// Sixteenth fall lets go of the line
						if (s_ff.cnt == sarr_pkg::CNT_RELEASE) begin
							nxt_s.oe = 1'b0;
							nxt_s.mode = sarr_pkg::ST_DONE;
						end
					end
				end
				sarr_pkg::ST_DONE: begin
					// Wait for select to rise before a new frame
					// Further falls are ignored; extra clocks read a released line
					nxt_s.oe = 1'b0;
				end
			endcase
		end
	end

	// State register; pins idle high so no false edge after reset
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_ff <= '{mode: sarr_pkg::ST_IDLE, sclk_q: 1'b1, cs_q_n: 1'b1,
				cnt: 5'h00, trial: 12'h000, mask: 12'h000, dout: 1'b0,
				oe: 1'b0, sample: 1'b0, result: 12'h000, res_valid: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from the state register
	assign o_serial_result_out = s_ff.dout;
	assign o_serial_result_oe = s_ff.oe;
	assign o_dac_trial = s_ff.trial;
	assign o_sample_hold = s_ff.sample;
	assign o_result = s_ff.result;
	assign o_result_valid = s_ff.res_valid;
endmodule : sarr_readout

// ### sarr_pkg.sv
// Shared constants and carriers for the serial result readout.
// Assumes a single 20 MHz core clock; all link pins sampled on it.
package sarr_pkg;
	// ==========================================================
	// Frame layout
	localparam int RES_BITS = 12;
	localparam int LEAD_ZEROS = 4;
	localparam int FRAME_FALLS = 16;
	localparam logic [4:0] CNT_LAST_DECIDE = 5'h0B;
	localparam logic [4:0] CNT_FIRST_DATA = 5'h03;
	localparam logic [4:0] CNT_RELEASE = 5'h0F;
	localparam logic [11:0] TRIAL_START = 12'h800;
	localparam logic [11:0] ZERO_CODE = 12'h000;
	localparam int FIFO_DEPTH = 8;

	// ==========================================================
	// Timing
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
	localparam int QUIET_MIN_NS = 60;
	localparam int QUIET_MIN_CYC = (QUIET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DRIVE_MAX_NS = 20;
	localparam int DRIVE_MAX_CYC = (DRIVE_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(DRIVE_MAX_NS / CLK_PERIOD_NS);
	localparam int POWERUP_MAX_NS = 1000;
	localparam int POWERUP_MAX_CYC = POWERUP_MAX_NS / CLK_PERIOD_NS;

	// ==========================================================
	// Sequencer and bit buffer state
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CONV = 3'b010,
		ST_DONE = 3'b100
	} sarr_mode_e;

	typedef struct packed {
		sarr_mode_e mode;
		logic sclk_q;
		logic cs_q_n;
		logic [4:0] cnt;
		logic [11:0] trial;
		logic [11:0] mask;
		logic dout;
		logic oe;
		logic sample;
		logic [11:0] result;
		logic res_valid;
	} sarr_state_s;

	typedef struct packed {
		logic [3:0] cnt;
		logic [2:0] wr_ptr;
		logic [2:0] rd_ptr;
	} sarr_fifo_s;
endpackage : sarr_pkg

// ### sarr_readout_assertions.sv
// Checker for the readout top; sees only its ports.
// Assumes select and serial clock sit high while reset is held.
module sarr_readout_assertions (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Host link
	input wire logic i_select_n,
	input wire logic i_sclk,
	input wire logic o_serial_result_out,
	input wire logic o_serial_result_oe,
	// Converter side
	input wire logic [11:0] o_dac_trial,
	input wire logic o_sample_hold,
	input wire logic [11:0] o_result,
	input wire logic o_result_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic sclk_ff;
	logic fall;
	logic [4:0] falls_ff;
	// Falls per frame; a raised select clears the count
	assign fall = sclk_ff & ~i_sclk;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sclk_ff <= 1'b1;
			falls_ff <= 5'h00;
		end else begin
			sclk_ff <= i_sclk;
			falls_ff <= i_select_n ? 5'h00 : falls_ff + 5'(fall);
		end
	end
	sequence s_pulse;
		o_result_valid ##1 !o_result_valid;
	endsequence
	a_start_answer: assert property ($fell(i_select_n) |=> o_sample_hold
		&& o_serial_result_oe && !o_serial_result_out && o_dac_trial == 12'h800)
		else $error("start answer wrong");
	a_select_release: assert property (i_select_n |=> !o_serial_result_oe)
		else $error("driving with select high");
	a_out_on_fall: assert property (o_serial_result_oe && $changed(o_serial_result_out)
		|-> $past(fall)) else $error("data moved off a fall");
	a_lead_zeros: assert property (o_serial_result_oe && falls_ff < 5'h04
		|-> !o_serial_result_out) else $error("leading bit not zero");
	a_result_steady: assert property ($changed(o_result) |-> o_result_valid)
		else $error("result moved without valid");
	a_result_after_twelve: assert property (fall && falls_ff == 5'h0B
		&& !i_select_n |=> s_pulse) else $error("result pulse missing");
	a_trial_steps: assert property (o_serial_result_oe && $changed(o_dac_trial)
		|-> $past(fall) || o_sample_hold) else $error("trial moved off a fall");
	a_release_sixteen: assert property (fall && falls_ff == 5'h0F |=> !o_serial_result_oe)
		else $error("no release after last fall");
endmodule : sarr_readout_assertions

bind sarr_readout sarr_readout_assertions i_chk (.i_clk, .i_rst, .i_select_n, .i_sclk,
	.o_serial_result_out, .o_serial_result_oe, .o_dac_trial, .o_sample_hold, .o_result,
	.o_result_valid);

// ### sarr_host.sv
// Host model: frames readouts with select and serial clock.
// Assumes the bench clock; drives on its falling edge.
module sarr_host (
	// Clock
	input wire logic i_clk,
	// Link
	output logic o_select_n,
	output logic o_sclk,
	input wire logic i_serial_result_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_select_n = 1'b1;
		o_sclk = 1'b1;
	end
	// Four-cycle serial clock so the core sees every level
	task automatic frame(input int n, output logic [15:0] w);
		w = 16'h0000;
		@(negedge i_clk) o_select_n = 1'b0;
		repeat (2) @(negedge i_clk);
		for (int i = 0; i < n; i++) begin
			w = {w[14:0], i_serial_result_out};
			o_sclk = 1'b0;
			repeat (2) @(negedge i_clk);
			o_sclk = 1'b1;
			repeat (2) @(negedge i_clk);
		end
	endtask : frame
	// Quiet gap rounded up to whole cycles; never shorter than the minimum
	task automatic stop();
		o_select_n = 1'b1;
		repeat (sarr_pkg::QUIET_MIN_CYC) @(negedge i_clk);
	endtask : stop
endmodule : sarr_host

// ### tb.sv
// Bench for the serial result readout.
// Assumes the host model and checker are compiled first.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sel_n, sclk, sdo, oe, pin, hold, vld;
	logic [11:0] level = 12'h000;
	logic [11:0] trial, res;
	logic [15:0] w;
	logic [11:0] codes [4] = '{12'h000, 12'hFFF, 12'hA5A, 12'h801};
	int mismatches = 0;
	int checked = 0;
	int pulses = 0;
	int holds = 0;
	always #25 clk = ~clk;
	// A released line reads inverted so stale data never passes
	assign pin = oe ? sdo : ~sdo;
	// Pulses are counted mid-cycle, where they stand settled
	always @(negedge clk) begin
		if (vld === 1'b1) begin
			pulses++;
		end
		if (hold === 1'b1) begin
			holds++;
		end
	end
	sarr_host i_host (.i_clk(clk), .o_select_n(sel_n), .o_sclk(sclk), .i_serial_result_out(pin));
	sarr_readout i_dut (.i_clk(clk), .i_rst(rst), .i_select_n(sel_n), .i_sclk(sclk),
		.o_serial_result_out(sdo), .o_serial_result_oe(oe), .i_cmp_above(level >= trial),
		.o_dac_trial(trial), .o_sample_hold(hold), .o_result(res), .o_result_valid(vld));
	task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s exp %h got %h", what, exp, got);
		end
	endtask : cmp16
	task automatic end_sim();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	// Full frame, select left low past the last fall
	task automatic t_conv(input logic [11:0] code);
		int n;
		int h;
		n = pulses;
		h = holds;
		level = code;
		i_host.frame(sarr_pkg::FRAME_FALLS, w);
		cmp16("word", {4'h0, code}, w);
		cmp16("result", {4'h0, code}, {4'h0, res});
		cmp16("result pulses", 16'(n + 1), pulses[15:0]);
		cmp16("sample pulses", 16'(h + 1), holds[15:0]);
		cmp16("released", 16'h0000, {15'h0, oe});
		i_host.stop();
	endtask : t_conv
	// Two extra falls after the frame find the line released
	task automatic t_overrun(input logic [11:0] code);
		int n;
		n = pulses;
		level = code;
		i_host.frame(18, w);
		cmp16("overrun word", {2'b00, code, 2'b11}, w);
		cmp16("overrun result", {4'h0, code}, {4'h0, res});
		cmp16("overrun pulses", 16'(n + 1), pulses[15:0]);
		i_host.stop();
	endtask : t_overrun
	// Select raised mid-frame gives no result
	task automatic t_abort();
		int n;
		int h;
		n = pulses;
		h = holds;
		level = 12'h3C3;
		i_host.frame(6, w);
		i_host.stop();
		cmp16("abort oe", 16'h0000, {15'h0, oe});
		cmp16("abort holds", 16'(h + 1), holds[15:0]);
		cmp16("abort pulses", n[15:0], pulses[15:0]);
	endtask : t_abort
	// Watchdog: a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_sim();
	end
	initial begin
		repeat (5) @(negedge clk);
		cmp16("reset", 16'h0000, {3'h0, oe, res});
		rst = 1'b0;
		// Power-up allowance before the first result is trusted
		repeat (sarr_pkg::POWERUP_MAX_CYC) @(negedge clk);
		foreach (codes[i]) begin
			t_conv(codes[i]);
		end
		t_abort();
		t_conv(12'h6B9);
		t_overrun(12'h5A3);
		end_sim();
	end
endmodule : tb
